// File: eeps_regs.vh
// Constants of the serial EEPROM command and protection block
`ifndef EEPS_REGS_VH
`define EEPS_REGS_VH
// Opcodes
`define EEPS_OP_SET_WL 8'h06
`define EEPS_OP_CLR_WL 8'h04
`define EEPS_OP_STAT_RD 8'h05
`define EEPS_OP_STAT_WR 8'h01
`define EEPS_OP_READ 8'h03
`define EEPS_OP_WRITE 8'h02
// Status register fields
`define EEPS_SR_PGE 7
`define EEPS_SR_BGH 3
`define EEPS_SR_BGL 2
`define EEPS_SR_ZERO 3'h0
`define EEPS_GUARD_RST 2'h0
`define EEPS_PGE_RST 1'h0
// Block guard codes
`define EEPS_BG_QTR 2'h1
`define EEPS_BG_HALF 2'h2
`define EEPS_BG_ALL 2'h3
// Page layout
`define EEPS_PAGE_BYTES 32
`define EEPS_PAGE_W 5
// Timing
`define EEPS_CLK_NS 25
`define EEPS_TWC_NS 5000000
// Pin vector layout and idle levels
`define EEPS_PINS 5
`define EEPS_PIN_SCK 0
`define EEPS_PIN_CS 1
`define EEPS_PIN_SI 2
`define EEPS_PIN_HOLD 3
`define EEPS_PIN_WP 4
`define EEPS_PIN_IDLE 5'h1A
// Write FIFO
`define EEPS_FIFO_DEPTH 16
`define EEPS_FIFO_AW 4
`endif

// File: eeps_core.v
// Serial EEPROM command decoder, status register, protection and write FIFO
`timescale 1ns/1ps
`include "eeps_regs.vh"

// ************************************************
// Write data FIFO
// ************************************************
module eeps_fifo #(
   parameter W = 13,
   parameter D = 16,
   parameter AW = 4
) (
   input wire clk_sys,
   input wire nrst,
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data
);
   localparam [AW:0] DEPTH_C = D[AW:0];
   reg [W-1:0] mem_ff [0:D-1];
   reg [AW-1:0] wr_ff;
   reg [AW-1:0] rd_ff;
   reg [AW:0] cnt_ff;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;

   // Honest full and empty
   assign in_ready = (cnt_ff != DEPTH_C);
   assign out_valid = (cnt_ff != {(AW+1){1'b0}});
   assign out_data = mem_ff[rd_ff];

   // Pointers and fill count
   always @(posedge clk_sys) begin
      if (!nrst) begin
         wr_ff <= {AW{1'b0}};
         rd_ff <= {AW{1'b0}};
         cnt_ff <= {(AW+1){1'b0}};
      end else begin
         if (push)
            wr_ff <= wr_ff + {{(AW-1){1'b0}}, 1'b1};
         if (pop)
            rd_ff <= rd_ff + {{(AW-1){1'b0}}, 1'b1};
         if (push & ~pop)
            cnt_ff <= cnt_ff + {{AW{1'b0}}, 1'b1};
         else if (pop & ~push)
            cnt_ff <= cnt_ff - {{AW{1'b0}}, 1'b1};
      end
   end

   // Storage
   always @(posedge clk_sys) begin
      if (push)
         mem_ff[wr_ff] <= in_data;
   end
endmodule

// ************************************************
// Device core
// ************************************************
module eeps_core #(
   parameter AW = 11,
   parameter integer PROG_CYCLES = `EEPS_TWC_NS / `EEPS_CLK_NS
) (
   input wire clk_sys,
   input wire nrst,
   input wire spi_sck,
   input wire spi_cs_n,
   input wire spi_si,
   input wire spi_hold_n,
   input wire spi_wp_n,
   output wire spi_so,
   output wire spi_so_oe_n
);
   localparam PW = AW - `EEPS_PAGE_W;
   localparam DEPTH = 1 << AW;
   localparam FW = `EEPS_PAGE_W + 8;
   localparam [1:0] PH_OP = 2'h0;
   localparam [1:0] PH_ADR = 2'h1;
   localparam [1:0] PH_DAT = 2'h2;
   localparam [1:0] PH_IGN = 2'h3;
   localparam [31:0] PROG_LAST = PROG_CYCLES - 1;

   reg [`EEPS_PINS-1:0] pin_s1_ff;
   reg [`EEPS_PINS-1:0] pin_s2_ff;
   reg [`EEPS_PINS-1:0] pin_s3_ff;
   reg [1:0] phase_ff;
   reg [2:0] bit_ff;
   reg [6:0] sh_ff;
   reg [7:0] op_ff;
   reg adr_cnt_ff;
   reg [7:0] adr_hi_ff;
   reg got_ff;
   reg lost_ff;
   reg wpseen_ff;
   reg [7:0] sr_new_ff;
   reg [PW-1:0] page_ff;
   reg [`EEPS_PAGE_W-1:0] ofs_ff;
   reg wel_ff;
   reg [1:0] bg_ff;
   reg pge_ff;
   reg pend_ff;
   reg busy_ff;
   reg kind_ff;
   reg [31:0] prog_cnt_ff;
   reg [AW-1:0] rd_ptr_ff;
   reg [7:0] out_sh_ff;
   reg [2:0] obit_ff;
   reg out_act_ff;
   reg drv_ff;
   reg so_ff;
   reg so_oe_n_ff;
   reg [7:0] pbuf_ff [0:`EEPS_PAGE_BYTES-1];
   reg [`EEPS_PAGE_BYTES-1:0] pmask_ff;
   reg [7:0] mem_ff [0:DEPTH-1];
   integer i;

   // Guard decode of the two top address bits
   function prot_hit;
      input [1:0] bg;
      input [1:0] top;
      begin
         case (bg)
            `EEPS_BG_QTR: prot_hit = (top == 2'h3);
            `EEPS_BG_HALF: prot_hit = top[1];
            `EEPS_BG_ALL: prot_hit = 1'b1;
            default: prot_hit = 1'b0;
         endcase
      end
   endfunction

   // ************************************************
   // Pin synchronisers and edge detection
   // ************************************************
   always @(posedge clk_sys) begin
      if (!nrst) begin
         pin_s1_ff <= `EEPS_PIN_IDLE;
         pin_s2_ff <= `EEPS_PIN_IDLE;
         pin_s3_ff <= `EEPS_PIN_IDLE;
      end else begin
         pin_s1_ff <= {spi_wp_n, spi_hold_n, spi_si, spi_cs_n, spi_sck};
         pin_s2_ff <= pin_s1_ff;
         pin_s3_ff <= pin_s2_ff;
      end
   end

   wire sck_lvl = pin_s2_ff[`EEPS_PIN_SCK];
   wire sck_rise = sck_lvl & ~pin_s3_ff[`EEPS_PIN_SCK];
   wire sck_fall = ~sck_lvl & pin_s3_ff[`EEPS_PIN_SCK];
   wire cs_lo = ~pin_s2_ff[`EEPS_PIN_CS];
   wire cs_fall = cs_lo & pin_s3_ff[`EEPS_PIN_CS];
   wire cs_rise = ~cs_lo & ~pin_s3_ff[`EEPS_PIN_CS];
   wire hold_ok = pin_s2_ff[`EEPS_PIN_HOLD];
   wire si_bit = pin_s2_ff[`EEPS_PIN_SI];
   wire wp_lo = ~pin_s2_ff[`EEPS_PIN_WP];
   // Clock edges count only while selected and not paused
   wire act_rise = sck_rise & cs_lo & hold_ok;
   wire act_fall = sck_fall & cs_lo & hold_ok;

   // ************************************************
   // Decode
   // ************************************************
   wire [7:0] rx_byte = {sh_ff, si_bit};
   wire byte_done = act_rise & (bit_ff == 3'h7);
   wire busy = busy_ff | pend_ff;
   wire [7:0] status = {pge_ff, `EEPS_SR_ZERO, bg_ff, wel_ff, busy};
   wire dec_go = byte_done & (phase_ff == PH_OP) & (~busy | (rx_byte == `EEPS_OP_STAT_RD));
   wire [15:0] adr_full = {adr_hi_ff, rx_byte};
   wire adr_done = byte_done & (phase_ff == PH_ADR) & adr_cnt_ff;
   wire end_ok = cs_rise & (phase_ff == PH_DAT) & (bit_ff == 3'h0);
   wire wr_ok = (op_ff == `EEPS_OP_WRITE) & got_ff & wel_ff & ~lost_ff
                & ~prot_hit(bg_ff, page_ff[PW-1:PW-2]);
   wire sr_ok = (op_ff == `EEPS_OP_STAT_WR) & got_ff & wel_ff
                & ~(pge_ff & (wpseen_ff | wp_lo));
   wire wl_ok = (op_ff == `EEPS_OP_SET_WL) & ~got_ff;
   wire prog_done = busy_ff & (prog_cnt_ff == PROG_LAST);
   wire [AW-1:0] rd_nxt = rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
   wire fifo_in_rdy;
   wire fifo_out_vld;
   wire [FW-1:0] fifo_out;
   wire fifo_push = byte_done & (phase_ff == PH_DAT) & (op_ff == `EEPS_OP_WRITE);
   wire fifo_out_rdy = ~sck_lvl | pend_ff;
   wire fifo_pop = fifo_out_vld & fifo_out_rdy;

   // ************************************************
   // Serial input sequencer
   // ************************************************
   always @(posedge clk_sys) begin
      if (!nrst) begin
         phase_ff <= PH_OP;
         bit_ff <= 3'h0;
         sh_ff <= 7'h00;
         op_ff <= 8'h00;
         adr_cnt_ff <= 1'b0;
         adr_hi_ff <= 8'h00;
         got_ff <= 1'b0;
         lost_ff <= 1'b0;
         sr_new_ff <= 8'h00;
         page_ff <= {PW{1'b0}};
         ofs_ff <= {`EEPS_PAGE_W{1'b0}};
      end else if (cs_fall | cs_rise) begin
         phase_ff <= PH_OP;
         bit_ff <= 3'h0;
         adr_cnt_ff <= 1'b0;
         got_ff <= 1'b0;
         lost_ff <= 1'b0;
      end else if (act_rise) begin
         sh_ff <= rx_byte[6:0];
         bit_ff <= bit_ff + 3'h1;
         if (bit_ff == 3'h7) begin
            case (phase_ff)
               PH_OP: begin
                  op_ff <= rx_byte;
                  if (!dec_go)
                     phase_ff <= PH_IGN;
                  else if (rx_byte == `EEPS_OP_READ || rx_byte == `EEPS_OP_WRITE)
                     phase_ff <= PH_ADR;
                  else if (rx_byte == `EEPS_OP_SET_WL || rx_byte == `EEPS_OP_STAT_RD
                           || rx_byte == `EEPS_OP_STAT_WR)
                     phase_ff <= PH_DAT;
                  else
                     phase_ff <= PH_IGN;
               end
               PH_ADR: begin
                  adr_hi_ff <= rx_byte;
                  adr_cnt_ff <= 1'b1;
                  if (adr_cnt_ff) begin
                     phase_ff <= PH_DAT;
                     page_ff <= adr_full[AW-1:`EEPS_PAGE_W];
                     ofs_ff <= adr_full[`EEPS_PAGE_W-1:0];
                  end
               end
               PH_DAT: begin
                  got_ff <= 1'b1;
                  if (op_ff == `EEPS_OP_WRITE) begin
                     ofs_ff <= ofs_ff + {{(`EEPS_PAGE_W-1){1'b0}}, 1'b1};
                     if (!fifo_in_rdy)
                        lost_ff <= 1'b1;
                  end
                  if (op_ff == `EEPS_OP_STAT_WR)
                     sr_new_ff <= rx_byte;
               end
               default: ;
            endcase
         end
      end
   end

   // Pin guard seen low at any time in the frame
   always @(posedge clk_sys) begin
      if (!nrst)
         wpseen_ff <= 1'b0;
      else if (cs_fall)
         wpseen_ff <= wp_lo;
      else if (cs_lo & wp_lo)
         wpseen_ff <= 1'b1;
   end

   // ************************************************
   // Write latch, guard bits and programming cycle
   // ************************************************
   always @(posedge clk_sys) begin
      if (!nrst) begin
         wel_ff <= 1'b0;
         bg_ff <= `EEPS_GUARD_RST;
         pge_ff <= `EEPS_PGE_RST;
         pend_ff <= 1'b0;
         busy_ff <= 1'b0;
         kind_ff <= 1'b0;
         prog_cnt_ff <= 32'h0;
      end else if (busy_ff) begin
         if (prog_done) begin
            busy_ff <= 1'b0;
            wel_ff <= 1'b0;
            if (kind_ff) begin
               bg_ff <= sr_new_ff[`EEPS_SR_BGH:`EEPS_SR_BGL];
               pge_ff <= sr_new_ff[`EEPS_SR_PGE];
            end
         end else begin
            prog_cnt_ff <= prog_cnt_ff + 32'h1;
         end
      end else if (pend_ff) begin
         // Wait until every loaded byte reached the page buffer
         if (!fifo_out_vld) begin
            pend_ff <= 1'b0;
            busy_ff <= 1'b1;
            prog_cnt_ff <= 32'h0;
         end
      end else if (end_ok & (wr_ok | sr_ok)) begin
         pend_ff <= 1'b1;
         kind_ff <= sr_ok;
      end else if (end_ok & wl_ok) begin
         wel_ff <= 1'b1;
      end else if (dec_go & (rx_byte == `EEPS_OP_CLR_WL)) begin
         wel_ff <= 1'b0;
      end
   end

   // ************************************************
   // Page buffer fed from the FIFO
   // ************************************************
   eeps_fifo #(
      .W(FW),
      .D(`EEPS_FIFO_DEPTH),
      .AW(`EEPS_FIFO_AW)
   ) u_fifo (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .in_valid(fifo_push),
      .in_ready(fifo_in_rdy),
      .in_data({ofs_ff, rx_byte}),
      .out_valid(fifo_out_vld),
      .out_ready(fifo_out_rdy),
      .out_data(fifo_out)
   );

   // Loaded-byte mask, cleared when a new write opcode arrives
   always @(posedge clk_sys) begin
      if (!nrst)
         pmask_ff <= {`EEPS_PAGE_BYTES{1'b0}};
      else if (dec_go & (rx_byte == `EEPS_OP_WRITE))
         pmask_ff <= {`EEPS_PAGE_BYTES{1'b0}};
      else if (fifo_pop)
         pmask_ff[fifo_out[FW-1:8]] <= 1'b1;
   end

   // Page buffer data, later bytes overwrite earlier ones
   always @(posedge clk_sys) begin
      if (fifo_pop)
         pbuf_ff[fifo_out[FW-1:8]] <= fifo_out[7:0];
   end

   // Array commit at the end of programming
   always @(posedge clk_sys) begin
      if (prog_done & ~kind_ff) begin
         for (i = 0; i < `EEPS_PAGE_BYTES; i = i + 1) begin
            if (pmask_ff[i])
               mem_ff[{page_ff, i[`EEPS_PAGE_W-1:0]}] <= pbuf_ff[i];
         end
      end
   end

   // ************************************************
   // Serial output
   // ************************************************
   always @(posedge clk_sys) begin
      if (!nrst) begin
         rd_ptr_ff <= {AW{1'b0}};
         out_sh_ff <= 8'h00;
         obit_ff <= 3'h0;
         out_act_ff <= 1'b0;
         drv_ff <= 1'b0;
         so_ff <= 1'b0;
      end else if (cs_fall | cs_rise) begin
         out_act_ff <= 1'b0;
         drv_ff <= 1'b0;
         obit_ff <= 3'h0;
      end else if (dec_go & (rx_byte == `EEPS_OP_STAT_RD)) begin
         out_act_ff <= 1'b1;
         out_sh_ff <= status;
      end else if (adr_done & (op_ff == `EEPS_OP_READ)) begin
         out_act_ff <= 1'b1;
         rd_ptr_ff <= adr_full[AW-1:0];
         out_sh_ff <= mem_ff[adr_full[AW-1:0]];
      end else if (act_fall & out_act_ff) begin
         drv_ff <= 1'b1;
         so_ff <= out_sh_ff[7];
         obit_ff <= obit_ff + 3'h1;
         if (obit_ff == 3'h7) begin
            if (op_ff == `EEPS_OP_READ) begin
               rd_ptr_ff <= rd_nxt;
               out_sh_ff <= mem_ff[rd_nxt];
            end else begin
               out_sh_ff <= status;
            end
         end else begin
            out_sh_ff <= {out_sh_ff[6:0], 1'b0};
         end
      end
   end

   // Output enable, low only while selected, not paused and sending
   always @(posedge clk_sys) begin
      if (!nrst)
         so_oe_n_ff <= 1'b1;
      else
         so_oe_n_ff <= ~(drv_ff & cs_lo & hold_ok);
   end

   assign spi_so = so_ff;
   assign spi_so_oe_n = so_oe_n_ff;
endmodule

// File: eeps_core_props.sv
// Pin-level checks for the serial EEPROM core
`timescale 1ns/1ps
module eeps_props (
   input wire clk_sys,
   input wire nrst,
   input wire spi_sck,
   input wire spi_cs_n,
   input wire spi_si,
   input wire spi_hold_n,
   input wire spi_wp_n,
   input wire spi_so,
   input wire spi_so_oe_n
);
   reg [3:0] rise_cnt_ff;
   reg sck_d_ff;
   wire live;
   // Selected and not paused
   assign live = !spi_cs_n && spi_hold_n;
   // Count host clock rises inside a frame, saturating
   always @(posedge clk_sys) begin
      sck_d_ff <= spi_sck;
      if (!nrst || spi_cs_n)
         rise_cnt_ff <= 4'h0;
      else if (spi_sck && !sck_d_ff && rise_cnt_ff != 4'hF)
         rise_cnt_ff <= rise_cnt_ff + 4'h1;
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   sequence s_deselected;
      spi_cs_n[*4];
   endsequence
   sequence s_paused;
      (!spi_hold_n)[*5];
   endsequence
   sequence s_sck_high;
      spi_sck[*4];
   endsequence
   a_deselect_quiet: assert property (s_deselected |-> spi_so_oe_n)
      else $error("output driven while deselected");
   a_deselect_bound: assert property ($rose(spi_cs_n) |-> ##[1:5] spi_so_oe_n)
      else $error("output not released after select rise");
   a_pause_release: assert property (s_paused |-> spi_so_oe_n)
      else $error("output driven during pause");
   a_drive_live: assert property ($fell(spi_so_oe_n) |-> live && $past(live))
      else $error("output enabled outside a live frame");
   a_opcode_first: assert property ($fell(spi_so_oe_n) |-> rise_cnt_ff >= 4'h8)
      else $error("output enabled before a full opcode");
   a_so_high_hold: assert property (s_sck_high |-> $stable(spi_so))
      else $error("output data moved while clock high");
   a_oe_high_hold: assert property (s_sck_high |-> $stable(spi_so_oe_n))
      else $error("output enable moved while clock high");
   a_reset_idle: assert property ($rose(nrst) |-> spi_so_oe_n && !spi_so)
      else $error("output not idle after reset");
endmodule
bind eeps_core eeps_props eeps_props_i (.clk_sys(clk_sys), .nrst(nrst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
   .spi_si(spi_si), .spi_hold_n(spi_hold_n), .spi_wp_n(spi_wp_n), .spi_so(spi_so), .spi_so_oe_n(spi_so_oe_n));

// File: eeps_host.sv
// Host controller model for the serial EEPROM pins
`timescale 1ns/1ps
module eeps_host (
   output reg spi_sck,
   output reg spi_cs_n,
   output reg spi_si,
   output reg spi_hold_n,
   input wire spi_so,
   input wire spi_so_oe_n
);
   reg pause_oe;
   // Idle levels
   initial begin
      spi_sck = 1'h0;
      spi_cs_n = 1'h1;
      spi_si = 1'h0;
      spi_hold_n = 1'h1;
      pause_oe = 1'h0;
   end
   // Open a frame
   task start;
      begin
         spi_cs_n = 1'h0;
         #100;
      end
   endtask
   // Close a frame, data line keeps moving while unused
   task stop;
      begin
         #100;
         spi_cs_n = 1'h1;
         spi_si = ~spi_si;
         #300;
      end
   endtask
   // One byte MSB first, mode 0, optional pause before bit 3
   task xfer(input [7:0] tx, input pz, output [7:0] rx, output drv);
      integer i;
      begin
         drv = 1'h0;
         for (i = 7; i >= 0; i = i - 1) begin
            if (pz && i == 3) begin
               #100; // Let the clock fall settle before pausing
               spi_hold_n = 1'h0;
               #150;
               spi_si = ~spi_si;
               #100;
               pause_oe = spi_so_oe_n;
               spi_hold_n = 1'h1;
               #100;
            end
            spi_si = tx[i];
            #100;
            spi_sck = 1'h1;
            #95;
            rx[i] = (spi_so_oe_n === 1'h0) ? spi_so : ~spi_so; // Released line carries no valid data
            if (spi_so_oe_n === 1'h0)
               drv = 1'h1;
            #5;
            spi_sck = 1'h0;
         end
      end
   endtask
endmodule

// File: tb_top.sv
// Self-checking bench for the serial EEPROM core
`timescale 1ns/1ps
`include "eeps_regs.vh"
module tb_top;
   reg clk_sys;
   reg nrst;
   reg spi_wp_n;
   wire spi_sck, spi_cs_n, spi_si, spi_hold_n, spi_so, spi_so_oe_n;
   integer fail_count, check_count, cyc, i, k, n;
   integer mem [0:2047];
   reg pge, write_enable_latch, acc, np, drv;
   reg [1:0] bg, nbg;
   reg [7:0] rx, d;
   reg [15:0] a;
   eeps_core #(.AW(11), .PROG_CYCLES(400)) eeps_core_i (.clk_sys(clk_sys), .nrst(nrst), .spi_sck(spi_sck),
      .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_hold_n(spi_hold_n), .spi_wp_n(spi_wp_n), .spi_so(spi_so),
      .spi_so_oe_n(spi_so_oe_n));
   eeps_host eeps_host_i (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_hold_n(spi_hold_n),
      .spi_so(spi_so), .spi_so_oe_n(spi_so_oe_n));
   // *****
   // Clock, timeout and helpers
   // *****
   always #12.5 clk_sys = ~clk_sys;
   // Cut a hang short
   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      if (cyc == 90000) begin
         fail_count = fail_count + 1;
         end_sim;
      end
   end
   task end_sim;
      begin
         $display("checks %0d mismatches %0d", check_count, fail_count);
         if (fail_count == 0 && check_count > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task chk(input [7:0] got, input integer exp, input string what);
      begin
         if (exp >= 0) begin
            check_count = check_count + 1;
            if (got !== exp[7:0]) begin
               fail_count = fail_count + 1;
               $display("mismatch at %0t: %0s got %h want %h", $time, what, got, exp[7:0]);
            end
         end
      end
   endtask
   function [7:0] sr(input b);
      sr = {pge, 3'h0, bg, write_enable_latch, b};
   endfunction
   function guarded(input [10:0] ad);
      guarded = (bg == 2'h3) || (bg == 2'h2 && ad >= 11'h400) || (bg == 2'h1 && ad >= 11'h600);
   endfunction
   task xb(input [7:0] v, input pz);
      eeps_host_i.xfer(v, pz, rx, drv);
   endtask
   task open;
      begin
         @(posedge clk_sys);
         #2;
         eeps_host_i.start;
      end
   endtask
   task cmd(input [7:0] op, input extra);
      begin
         open;
         xb(op, 1'h0);
         if (extra)
            xb(8'h00, 1'h0);
         eeps_host_i.stop;
         if (op == `EEPS_OP_SET_WL && !extra)
            write_enable_latch = 1'h1;
         if (op == `EEPS_OP_CLR_WL)
            write_enable_latch = 1'h0;
      end
   endtask
   task status_read_cmd(output [7:0] s);
      begin
         open;
         xb(`EEPS_OP_STAT_RD, 1'h0);
         eeps_host_i.xfer(8'h00, 1'h0, s, drv);
         eeps_host_i.stop;
      end
   endtask
   task wait_ready(input b);
      reg [7:0] s;
      integer t;
      begin
         status_read_cmd(s);
         chk(s, sr(b), "busy status");
         t = 0;
         while (s[0] !== 1'h0 && t < 20) begin
            status_read_cmd(s);
            t = t + 1;
         end
         if (b) begin
            write_enable_latch = 1'h0;
            pge = np;
            bg = nbg;
         end
         np = pge;
         nbg = bg;
         chk(s, sr(0), "ready status");
      end
   endtask
   task wr(input [15:0] ad, input integer cnt, input pz);
      integer j;
      begin
         acc = write_enable_latch && !guarded(ad[10:0]);
         open;
         xb(`EEPS_OP_WRITE, 1'h0);
         xb(ad[15:8], 1'h0);
         xb(ad[7:0], 1'h0);
         for (j = 0; j < cnt; j = j + 1) begin
            d = 8'($urandom);
            xb(d, pz && j == 1);
            if (acc)
               mem[ad[10:5] * 32 + (ad[4:0] + j) % 32] = d;
         end
         eeps_host_i.stop;
      end
   endtask
   task rd(input [15:0] ad, input integer cnt, input pz);
      integer j;
      begin
         open;
         xb(`EEPS_OP_READ, 1'h0);
         xb(ad[15:8], 1'h0);
         xb(ad[7:0], 1'h0);
         for (j = 0; j < cnt; j = j + 1) begin
            xb(8'h00, pz && j == 1);
            chk(rx, mem[(ad[10:0] + j) % 2048], "array data");
         end
         eeps_host_i.stop;
         if (pz)
            chk({7'h0, eeps_host_i.pause_oe}, 1, "pause release");
      end
   endtask
   task status_write_cmd(input [7:0] v);
      begin
         acc = write_enable_latch && !(pge && !spi_wp_n);
         if (acc) begin
            np = v[7];
            nbg = v[3:2];
         end
         open;
         xb(`EEPS_OP_STAT_WR, 1'h0);
         xb(v, 1'h0);
         eeps_host_i.stop;
      end
   endtask
   // *****
   // Main sequence
   // *****
   initial begin
      clk_sys = 1'h0;
      nrst = 1'h0;
      spi_wp_n = 1'h1;
      fail_count = 0;
      check_count = 0;
      cyc = 0;
      {pge, write_enable_latch, np, bg, nbg} = 7'h00;
      for (i = 0; i < 2048; i = i + 1)
         mem[i] = -1;
      i = $urandom(32'h8B5AB5A8);
      repeat (10) @(posedge clk_sys);
      #2;
      nrst = 1'h1;
      repeat (8) @(posedge clk_sys);
      #2;
      chk({7'h0, spi_so_oe_n}, 1, "idle output");
      status_read_cmd(rx);
      chk(rx, sr(0), "reset status");
      $display("test reset done");
      cmd(8'hA5, 1'h0);
      cmd(`EEPS_OP_SET_WL, 1'h1);
      status_read_cmd(rx);
      chk(rx, sr(0), "latch after long enable");
      cmd(`EEPS_OP_SET_WL, 1'h0);
      status_read_cmd(rx);
      chk(rx, sr(0), "latch set");
      cmd(`EEPS_OP_CLR_WL, 1'h0);
      status_read_cmd(rx);
      chk(rx, sr(0), "latch cleared");
      $display("test opcodes done");
      cmd(`EEPS_OP_SET_WL, 1'h0);
      wr(16'hF8FE, 34, 1'h1);
      open;
      xb(`EEPS_OP_READ, 1'h0);
      xb(8'h00, 1'h0);
      xb(8'hE0, 1'h0);
      xb(8'h00, 1'h0);
      eeps_host_i.stop;
      chk({7'h0, drv}, 0, "read while busy");
      wait_ready(acc);
      rd(16'h00E0, 32, 1'h1);
      wr(16'h00E0, 1, 1'h0);
      wait_ready(acc);
      rd(16'h00E0, 1, 1'h0);
      $display("test page write done");
      for (n = 0; n < 2; n = n + 1) begin
         cmd(`EEPS_OP_SET_WL, 1'h0);
         wr(n ? 16'h07FF : 16'h0000, 1, 1'h0);
         wait_ready(acc);
      end
      rd(16'h07FF, 2, 1'h0);
      $display("test read wrap done");
      for (k = 0; k < 4; k = k + 1) begin
         cmd(`EEPS_OP_SET_WL, 1'h0);
         status_write_cmd({4'h7, k[1:0], 2'h3});
         wait_ready(acc);
         for (n = 0; n < 3; n = n + 1) begin
            a = (n == 0) ? 16'h0000 : (n == 1) ? 16'h0400 : 16'h0600;
            cmd(`EEPS_OP_SET_WL, 1'h0);
            wr(a, 1, 1'h0);
            wait_ready(acc);
            rd(a, 1, 1'h0);
         end
      end
      $display("test guard codes done");
      cmd(`EEPS_OP_SET_WL, 1'h0);
      status_write_cmd(8'h80);
      wait_ready(acc);
      @(posedge clk_sys);
      #2;
      spi_wp_n = 1'h0;
      cmd(`EEPS_OP_SET_WL, 1'h0);
      status_write_cmd(8'h0C);
      wait_ready(acc);
      @(posedge clk_sys);
      #2;
      spi_wp_n = 1'h1;
      cmd(`EEPS_OP_SET_WL, 1'h0);
      status_write_cmd(8'h00);
      wait_ready(acc);
      $display("test pin guard done");
      end_sim;
   end
endmodule
